// ---- dv/host_uart_model.sv ----
// Host side of the serial link, seen at the UART's parallel pins.
// Assumes the bench drives inject for one cycle per host character.
`timescale 1ns/1ps
module host_uart_model (
    input wire pclk,
    input wire presetn,
    input wire tx_load,
    input wire rx_flag_reset_n,
    input wire inject,
    input wire [7:0] inject_char,
    input wire [3:0] busy_len,
    output reg tx_ready,
    output reg rx_data_available,
    output reg [7:0] rx_data
);
    reg [3:0] busy_reg;

    // Transmitter stays busy busy_len cycles per character loaded.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b1;
            busy_reg <= 4'h0;
        end else if (tx_load) begin
            busy_reg <= busy_len;
            tx_ready <= (busy_len == 4'h0);
        end else if (busy_reg != 4'h0) begin
            busy_reg <= busy_reg - 4'h1;
            tx_ready <= (busy_reg == 4'h1);
        end
    end

    // flag raise and clear.
    // Data lines wander while no character is held, so stale use shows.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_available <= 1'b0;
            rx_data <= 8'h55;
        end else if (inject) begin
            rx_data_available <= 1'b1;
            rx_data <= inject_char;
        end else if (!rx_flag_reset_n) begin
            rx_data_available <= 1'b0;
        end else if (!rx_data_available) begin
            rx_data <= ~rx_data;
        end
    end
endmodule // host_uart_model

// ---- dv/terminal_keyboard_line_router_properties.sv ----
// Concurrent checks on the keyboard router's top-level ports.
// Assumes mode levels stay static around each key strobe.
`timescale 1ns/1ps
`include "kbd_router_defs.vh"
module kbd_router_checker #(
    parameter DEBOUNCE_CYCLES = 20,
    parameter STROBE_CYCLES = 10
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    input wire irq,
    input wire key_down,
    input wire key_strobe,
    input wire [6:0] key_code,
    input wire mode_online,
    input wire [7:0] tx_data,
    input wire tx_load,
    input wire rx_flag_reset_n
);
    reg [31:0] hi_cnt;
    reg [31:0] down_cnt;
    wire apb_wr = psel && penable && pwrite;
    wire st_wr = apb_wr && paddr == `ADDR_STATUS && pwdata[`ST_RX_AVAIL];

    // Length of the current strobe and of the current steady press.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 32'h0;
            down_cnt <= 32'h0;
        end else begin
            hi_cnt <= key_strobe ? hi_cnt + 32'h1 : 32'h0;
            down_cnt <= key_down ? down_cnt + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_strobe_width: assert property (
        $fell(key_strobe) |-> hi_cnt == STROBE_CYCLES)
        else $error("strobe width wrong");
    // Two cycles of slack cover the input synchronizer.
    chk_debounce_hold: assert property (
        $rose(key_strobe) |-> $past(down_cnt, 2) + 2 >= DEBOUNCE_CYCLES)
        else $error("strobe before debounce");
    chk_load_pulse: assert property (tx_load |=> !tx_load)
        else $error("tx load too long");
    chk_tx_code: assert property (
        tx_load && $rose(key_strobe) |-> tx_data == {1'b0, key_code})
        else $error("tx code wrong");
    chk_offline_no_tx: assert property (
        $rose(key_strobe) && !mode_online |-> !tx_load)
        else $error("offline key sent");
    chk_flag_pulse: assert property (
        !rx_flag_reset_n |=> rx_flag_reset_n)
        else $error("flag reset too long");
    chk_flag_cause: assert property (
        $fell(rx_flag_reset_n) |-> $past(st_wr) || $past(st_wr, 2))
        else $error("flag reset uncaused");
    chk_irq_clear: assert property (
        $fell(irq) |-> $past(apb_wr) || $past(apb_wr, 2))
        else $error("irq fell uncaused");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("pslverr out of phase");
endmodule // kbd_router_checker

bind terminal_keyboard_line_router kbd_router_checker #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .STROBE_CYCLES(STROBE_CYCLES)
) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pslverr, .irq, .key_down, .key_strobe, .key_code, .mode_online,
    .tx_data, .tx_load, .rx_flag_reset_n);

// ---- dv/terminal_keyboard_line_router_tb_top.sv ----
// Self-checking bench: every key with random modifiers, routing modes, APB and repeat.
// Assumes the design is built with shortened time parameters.
`timescale 1ns/1ps
`include "kbd_router_defs.vh"
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin \
    error_cnt = error_cnt + 1; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module terminal_keyboard_line_router_tb_top;
    localparam DEB = 20;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    reg [7:0] paddr = 0, inj_char = 0;
    reg [31:0] pwdata = 0, rd, r, seed = 55999;
    reg key_down = 0, key_shift = 0, key_ctrl = 0, key_num = 0;
    reg upper_case_latch = 0, repeat_key = 0, send_key = 0, inject = 0;
    reg display_enable = 0, mode_online = 0, mode_half_duplex = 0, ks_q = 0;
    reg [5:0] key_index = 0;
    reg [3:0] busy_len = 0;
    reg [6:0] got_code = 0, e;
    reg [7:0] got_tx = 0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, tx_ready, tx_load, rx_data_available;
    wire rx_flag_reset_n, key_strobe;
    wire [7:0] tx_data, rx_data;
    wire [6:0] key_code;
    integer error_cnt = 0, n_checks = 0, n_str = 0, n_tx = 0, de_cnt = 0;
    integer i, s0, t0;

    terminal_keyboard_line_router #(.DEBOUNCE_CYCLES(DEB),
        .STROBE_CYCLES(10), .HOLD_CYCLES(50)) u_dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .key_down, .key_index, .key_shift, .key_ctrl,
        .key_num, .upper_case_latch, .repeat_key, .send_key,
        .display_enable, .mode_online, .mode_half_duplex, .tx_ready,
        .rx_data_available, .rx_data, .tx_data, .tx_load,
        .rx_flag_reset_n, .key_strobe, .key_code);
    host_uart_model u_host (.pclk, .presetn, .tx_load, .rx_flag_reset_n,
        .inject, .inject_char(inj_char), .busy_len, .tx_ready,
        .rx_data_available, .rx_data);

    initial forever #4 pclk = ~pclk;

    // Strobes and loads are counted mid-cycle, away from the edge.
    always @(negedge pclk) begin
        ks_q <= key_strobe;
        if (key_strobe && !ks_q) begin
            n_str = n_str + 1;
            got_code = key_code;
        end
        if (tx_load) begin
            n_tx = n_tx + 1;
            got_tx = tx_data;
        end
    end

    // Free-running display enable, period twelve clocks.
    always @(posedge pclk) begin
        de_cnt <= (de_cnt == 5) ? 0 : de_cnt + 1;
        if (de_cnt == 5) display_enable <= ~display_enable;
    end

    function automatic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xs = seed;
    endfunction

    // Code the key should give; the digit overlay wins over all else.
    function automatic [6:0] exp_code(input [5:0] x, input s, c, n, l);
        reg [6:0] k, d;
        k = {1'b0, x} + 7'h20;
        d = k;
        // Unshifted keys at 0x40 and above give lower case; shift flips bit 4 below.
        if (k >= 7'h40 && !s) k = k | 7'h20;
        else if (k < 7'h40 && s) k = k ^ 7'h10;
        if (c) k = k & 7'h1f;
        if (l && k >= 7'h61 && k <= 7'h7a) k = k - 7'h20;
        if (n) case (d)
            7'h4a: k = 7'h34;
            7'h4b: k = 7'h35;
            7'h4c: k = 7'h36;
            7'h49: k = 7'h38;
            7'h4f: k = 7'h39;
            7'h56: k = 7'h30;
            default: ;
        endcase
        exp_code = k;
    endfunction

    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            k = k + 1;
            @(posedge pclk);
        end
        if (k == 50) `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // A one-cycle bounce, then a steady press; rk joins the repeat key.
    task press(input [5:0] x, input integer hold, input rk);
        @(posedge pclk) key_down <= 1'b1;
        @(posedge pclk) key_down <= 1'b0;
        @(posedge pclk) {key_index, key_down} <= {x, 1'b1};
        repeat (25) @(posedge pclk);
        repeat_key <= rk;
        repeat (hold) @(posedge pclk);
        {repeat_key, key_down} <= 2'b00;
        repeat (40) @(posedge pclk);
    endtask

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt = error_cnt + 1;
        $display("watchdog expired");
        report_and_stop;
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `ADDR_CTRL, 0); `CHK(rd, 32'h0)
        apb(0, `ADDR_MASK, 0); `CHK(rd, 32'h0)
        apb(1, 8'h3c, 32'hf); `CHK(err, 1'b1)
        apb(0, 8'h3c, 0); `CHK({err, rd}, {1'b1, 32'h0})
        $display("register test done");
        for (i = 0; i < 128; i = i + 1) begin
            r = xs();
            @(posedge pclk);
            {key_ctrl, key_num, upper_case_latch} <= {&r[1:0], r[3:2]};
            {mode_online, mode_half_duplex} <= r[5:4];
            {busy_len, key_shift} <= {2'b00, r[9:8], i[6]};
            e = exp_code(i[5:0], i[6], &r[1:0], r[3], r[2]);
            {s0, t0} = {n_str, n_tx};
            press(i[5:0], 10, 0);
            `CHK(n_str - s0, 1)
            `CHK(got_code, e)
            `CHK(n_tx - t0, {31'h0, r[5]})
            if (r[5]) `CHK(got_tx, {1'b0, e})
            apb(0, `ADDR_STATUS, 0);
            `CHK(rd[1:0], {1'b1, !r[5] || r[4]})
            apb(0, `ADDR_RX_DATA, 0);
            if (!r[5] || r[4]) `CHK(rd[6:0], e)
            apb(1, `ADDR_STATUS, 32'hf);
        end
        $display("key routing test done");
        {key_ctrl, key_num, upper_case_latch, key_shift} <= 4'h0;
        {mode_online, mode_half_duplex} <= 2'b11;
        apb(1, `ADDR_CTRL, 2);
        t0 = n_tx;
        press(6'h21, 10, 0);
        `CHK(n_tx - t0, 0)
        apb(0, `ADDR_STATUS, 0); `CHK(rd[0], 1'b0)
        apb(1, `ADDR_TX_DATA, 32'h41);
        repeat (3) @(posedge pclk);
        `CHK(got_tx, 8'h41)
        apb(1, `ADDR_CTRL, 1);
        t0 = n_tx;
        press(6'h22, 10, 0);
        `CHK(n_tx - t0, 0)
        apb(1, `ADDR_CTRL, 0);
        apb(1, `ADDR_STATUS, 32'hf);
        mode_online <= 1'b0;
        send_key <= 1'b1;
        repeat (DEB + 10) @(posedge pclk);
        send_key <= 1'b0;
        repeat (DEB + 10) @(posedge pclk);
        apb(0, `ADDR_STATUS, 0); `CHK(rd[2], 1'b1)
        apb(0, `ADDR_MODE, 0); `CHK(rd[5:0], 6'h06)
        apb(1, `ADDR_STATUS, 32'hf);
        {inject, inj_char} <= {1'b1, 8'h5a};
        @(posedge pclk) inject <= 1'b0;
        repeat (6) @(negedge pclk);
        `CHK(irq, 1'b0)
        apb(1, `ADDR_MASK, 1);
        @(negedge pclk) `CHK(irq, 1'b1)
        apb(0, `ADDR_RX_DATA, 0); `CHK(rd[7:0], 8'h5a)
        apb(1, `ADDR_STATUS, 1);
        repeat (3) @(negedge pclk);
        `CHK({irq, rx_data_available}, 2'b00)
        $display("processor test done");
        {mode_online, mode_half_duplex} <= 2'b10;
        s0 = n_str;
        press(6'h00, 300, 0);
        `CHK((n_str - s0) >= 4 && (n_str - s0) <= 8, 1'b1)
        s0 = n_str;
        repeat (100) @(posedge pclk);
        `CHK(n_str, s0)
        press(6'h25, 300, 1);
        `CHK(n_str - s0 >= 4, 1'b1)
        s0 = n_str;
        press(6'h25, 300, 0);
        `CHK(n_str - s0, 1)
        $display("repeat test done");
        report_and_stop;
    end
endmodule // terminal_keyboard_line_router_tb_top

// ---- hdl/kbd_router_defs.vh ----
// Constants for the terminal keyboard front end and character router.
// Assumes a single 125 MHz pclk domain and an APB register port.
`ifndef KBD_ROUTER_DEFS_VH
`define KBD_ROUTER_DEFS_VH

// Clock rate and documented times.
`define CLK_MHZ 125
`define DEBOUNCE_US 8000
`define STROBE_US 300
`define HOLD_US 1000000
`define REPEAT_DIV 4

// Register byte addresses.
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_MASK 8'h08
`define ADDR_RX_DATA 8'h0c
`define ADDR_TX_DATA 8'h10
`define ADDR_MODE 8'h14

// Control register fields.
`define CTRL_CPU_TX_OWN 0
`define CTRL_CPU_SENDING 1
`define CTRL_RESET 2'h0

// Status and mask fields.
`define ST_RX_AVAIL 0
`define ST_KEY_EVENT 1
`define ST_SEND_REQ 2
`define ST_OVERRUN 3
`define ST_WIDTH 4
`define MASK_RESET 4'h0

// Key code word: seven code bits plus the repeat flag.
`define CODE_REPEAT_BIT 7

`endif

// ---- hdl/key_code_rom.v ----
// Key code lookup memory: scan index plus modifiers in, code out.
// Assumes the address is steady for a cycle; data leaves a register.
`timescale 1ns/1ps
module key_code_rom (
    input wire pclk,
    input wire presetn,
    input wire [9:0] addr,
    output reg [7:0] data
);
    reg [6:0] base;
    reg [6:0] c;
    reg rep;
    wire [5:0] idx = addr[5:0];
    wire shift = addr[6];
    wire ctrl = addr[7];
    wire num = addr[8];
    wire ucl = addr[9];

    // -----------------------------------------------------------------
    // Table contents
    // -----------------------------------------------------------------
    // Contents are computed rather than stored, which keeps the table
    // tiny while still covering every code; index 0 is space.
    always @* begin
        base = {1'b0, idx} + 7'h20;
        c = base;
        if (c >= 7'h40 && !shift) begin
            c = c | 7'h20;
        end else if (c < 7'h40 && shift) begin
            c = c ^ 7'h10;
        end
        if (ucl && c >= 7'h61 && c <= 7'h7a) begin
            c = c & 7'h5f;
        end
        if (ctrl) begin
            c = c & 7'h1f;
        end
        // digit overlay keys
        // The overlay is applied last so no modifier can alter a digit.
        if (num) begin
            case (base)
                7'h4a: c = 7'h34;
                7'h4b: c = 7'h35;
                7'h4c: c = 7'h36;
                7'h49: c = 7'h38;
                7'h4f: c = 7'h39;
                7'h56: c = 7'h30;
                default: c = c;
            endcase
        end
        rep = (idx == 6'h00) || (idx == 6'h0e);
    end

    // Registered read port.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data <= 8'h00;
        end else begin
            data <= {rep, c};
        end
    end
endmodule // key_code_rom

// ---- hdl/terminal_keyboard_line_router.v ----
// Keyboard strobe, auto-repeat and character routing for a terminal.
// Assumes keyboard and UART pins are asynchronous; APB on pclk.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "kbd_router_defs.vh"
module terminal_keyboard_line_router #(
    parameter DEBOUNCE_CYCLES = `DEBOUNCE_US * `CLK_MHZ,
    parameter STROBE_CYCLES = `STROBE_US * `CLK_MHZ,
    parameter HOLD_CYCLES = `HOLD_US * `CLK_MHZ
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire irq,
    input wire key_down,
    input wire [5:0] key_index,
    input wire key_shift,
    input wire key_ctrl,
    input wire key_num,
    input wire upper_case_latch,
    input wire repeat_key,
    input wire send_key,
    input wire display_enable,
    input wire mode_online,
    input wire mode_half_duplex,
    input wire tx_ready,
    input wire rx_data_available,
    input wire [7:0] rx_data,
    output reg [7:0] tx_data,
    output reg tx_load,
    output reg rx_flag_reset_n,
    output reg key_strobe,
    output reg [6:0] key_code
);
    localparam SW = 26;
    // Counts arrive as 32-bit integers; every one fits in 27 bits.
    localparam [31:0] DEB_FULL = DEBOUNCE_CYCLES;
    localparam [31:0] STR_FULL = STROBE_CYCLES;
    localparam [31:0] HOLD_FULL = HOLD_CYCLES;
    localparam [31:0] DIV_FULL = `REPEAT_DIV - 1;
    localparam [26:0] DEB_MAX = DEB_FULL[26:0];
    localparam [26:0] STR_MAX = STR_FULL[26:0];
    localparam [26:0] HOLD_MAX = HOLD_FULL[26:0];
    localparam [1:0] DIV_LAST = DIV_FULL[1:0];

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    reg [SW-1:0] sync1_reg;
    reg [SW-1:0] sync2_reg;
    wire [SW-1:0] raw_in = {key_down, key_index, key_shift, key_ctrl,
        key_num, upper_case_latch, repeat_key, send_key, display_enable,
        mode_online, mode_half_duplex, tx_ready, rx_data_available, rx_data};
    wire key_s = sync2_reg[25];
    // Bit positions follow the order of raw_in, key_down on top.
    wire [9:0] rom_addr = {sync2_reg[15], sync2_reg[16], sync2_reg[17],
        sync2_reg[18], sync2_reg[25] ? sync2_reg[24:19] : 6'h0};
    wire repeat_s = sync2_reg[14];
    wire send_s = sync2_reg[13];
    wire de_s = sync2_reg[12];
    wire online_s = sync2_reg[11];
    wire half_s = sync2_reg[10];
    wire tx_ready_s = sync2_reg[9];
    wire dav_s = sync2_reg[8];
    wire shift_s = sync2_reg[18];
    wire [7:0] rxd_s = sync2_reg[7:0];

    // Two stages on every non-APB input pin; only the second stage feeds logic.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= {SW{1'b0}};
            sync2_reg <= {SW{1'b0}};
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire [7:0] rom_q;

    key_code_rom rom_u (
        .pclk(pclk),
        .presetn(presetn),
        .addr(rom_addr),
        .data(rom_q)
    );

    // -----------------------------------------------------------------
    // Debounce, hold timer and repeat divider
    // -----------------------------------------------------------------
    reg key_prev_reg;
    reg key_stable_reg;
    reg [26:0] deb_cnt_reg;
    reg key_rep_reg;
    reg [26:0] hold_cnt_reg;
    reg de_prev_reg;
    reg [1:0] div_reg;
    reg send_prev_reg;
    reg dav_prev_reg;
    reg send_shift_reg;

    wire deb_done = (deb_cnt_reg == DEB_MAX);
    wire key_stable_next = deb_done ? key_prev_reg : key_stable_reg;
    wire accept = key_stable_next & ~key_stable_reg;
    // release stops repeats
    // The raw level is used so repeats end without the debounce delay.
    wire held = key_stable_reg & key_s & (key_rep_reg | repeat_s);
    wire repeating = held & (hold_cnt_reg == HOLD_MAX);
    wire de_edge = de_s & ~de_prev_reg;
    wire tick = repeating & de_edge & (div_reg == DIV_LAST);
    wire trigger = accept | tick;

    // The counter restarts on every level change, so contact bounce
    // only stretches the wait and can never add a strobe.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_prev_reg <= 1'b0;
            key_stable_reg <= 1'b0;
            deb_cnt_reg <= 27'h0;
        end else begin
            key_prev_reg <= key_s;
            key_stable_reg <= key_stable_next;
            if (key_s != key_prev_reg) begin
                deb_cnt_reg <= 27'h0;
            end else if (!deb_done) begin
                deb_cnt_reg <= deb_cnt_reg + 27'h1;
            end
        end
    end

    // Hold timer and display-enable divider for repeats.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_rep_reg <= 1'b0;
            hold_cnt_reg <= 27'h0;
            de_prev_reg <= 1'b0;
            div_reg <= 2'h0;
        end else begin
            de_prev_reg <= de_s;
            if (accept) begin
                key_rep_reg <= rom_q[`CODE_REPEAT_BIT];
            end
            if (!held) begin
                hold_cnt_reg <= 27'h0;
            end else if (!repeating) begin
                hold_cnt_reg <= hold_cnt_reg + 27'h1;
            end
            if (!repeating) begin
                div_reg <= 2'h0;
            end else if (de_edge) begin
                div_reg <= div_reg + 2'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Strobe generator
    // -----------------------------------------------------------------
    reg [26:0] str_cnt_reg;
    wire [6:0] key_char = accept ? rom_q[6:0] : key_code;

    // A fresh trigger restarts the pulse; repeats are far slower than it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            str_cnt_reg <= 27'h0;
            key_strobe <= 1'b0;
            key_code <= 7'h00;
        end else begin
            if (trigger) begin
                key_code <= key_char;
                key_strobe <= 1'b1;
                str_cnt_reg <= 27'h1;
            end else if (key_strobe && str_cnt_reg == STR_MAX) begin
                key_strobe <= 1'b0;
                str_cnt_reg <= 27'h0;
            end else if (key_strobe) begin
                str_cnt_reg <= str_cnt_reg + 27'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------
    reg [1:0] ctrl_reg;
    reg [`ST_WIDTH-1:0] status_reg;
    reg [`ST_WIDTH-1:0] mask_reg;
    reg [7:0] rx_hold_reg;
    reg [`ST_WIDTH-1:0] set_bits;
    reg [31:0] rd_next;

    wire cpu_own = ctrl_reg[`CTRL_CPU_TX_OWN];
    wire cpu_sending = ctrl_reg[`CTRL_CPU_SENDING];
    wire wr = psel & penable & pwrite;
    wire hit = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS) ||
        (paddr == `ADDR_MASK) || (paddr == `ADDR_RX_DATA) ||
        (paddr == `ADDR_TX_DATA) || (paddr == `ADDR_MODE);
    wire wr_status = wr & (paddr == `ADDR_STATUS);
    wire [`ST_WIDTH-1:0] clr_bits = wr_status ? pwdata[`ST_WIDTH-1:0]
        : {`ST_WIDTH{1'b0}};

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign irq = |(status_reg & mask_reg);

    // -----------------------------------------------------------------
    // Routing of keyed and received characters
    // -----------------------------------------------------------------
    // suppress during buffer send
    wire blocked = cpu_sending;
    wire kb_owns = online_s & ~cpu_own;
    wire to_host = trigger & kb_owns & ~blocked;
    wire to_local = trigger & ~blocked & (~online_s | half_s);
    wire host_rx = dav_s & ~dav_prev_reg;
    wire cpu_tx = wr & (paddr == `ADDR_TX_DATA) & (cpu_own | cpu_sending);
    wire send_edge = send_s & ~send_prev_reg;

    // Event sources for the sticky status bits.
    always @* begin
        set_bits = {`ST_WIDTH{1'b0}};
        set_bits[`ST_RX_AVAIL] = host_rx | to_local;
        set_bits[`ST_KEY_EVENT] = trigger;
        set_bits[`ST_SEND_REQ] = send_edge & ~online_s;
        set_bits[`ST_OVERRUN] = ((to_host | cpu_tx) & ~tx_ready_s) |
            (host_rx & to_local);
    end

    // Transmitter load; a busy transmitter drops the character.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data <= 8'h00;
            tx_load <= 1'b0;
        end else begin
            tx_load <= 1'b0;
            if (to_host && tx_ready_s) begin
                tx_data <= {1'b0, key_char};
                tx_load <= 1'b1;
            end else if (cpu_tx && tx_ready_s) begin
                tx_data <= pwdata[7:0];
                tx_load <= 1'b1;
            end
        end
    end

    // Receive holding register; a host character wins over an echo.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold_reg <= 8'h00;
            dav_prev_reg <= 1'b0;
            send_prev_reg <= 1'b0;
            send_shift_reg <= 1'b0;
            rx_flag_reset_n <= 1'b1;
        end else begin
            dav_prev_reg <= dav_s;
            send_prev_reg <= send_s;
            if (host_rx) begin
                rx_hold_reg <= rxd_s;
            end else if (to_local) begin
                rx_hold_reg <= {1'b0, key_char};
            end
            if (send_edge) begin
                send_shift_reg <= shift_s;
            end
            rx_flag_reset_n <= ~clr_bits[`ST_RX_AVAIL];
        end
    end

    // Control, sticky status and mask; a set wins over a clear.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
            status_reg <= {`ST_WIDTH{1'b0}};
            mask_reg <= `MASK_RESET;
        end else begin
            status_reg <= (status_reg & ~clr_bits) | set_bits;
            if (wr && paddr == `ADDR_CTRL) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (wr && paddr == `ADDR_MASK) begin
                mask_reg <= pwdata[`ST_WIDTH-1:0];
            end
        end
    end

    // Read data is chosen in the setup cycle and held by a register.
    always @* begin
        rd_next = 32'h0;
        if (paddr == `ADDR_CTRL) begin
            rd_next[1:0] = ctrl_reg;
        end else if (paddr == `ADDR_STATUS) begin
            rd_next[`ST_WIDTH-1:0] = status_reg;
        end else if (paddr == `ADDR_MASK) begin
            rd_next[`ST_WIDTH-1:0] = mask_reg;
        end else if (paddr == `ADDR_RX_DATA) begin
            rd_next[7:0] = rx_hold_reg;
        end else if (paddr == `ADDR_MODE) begin
            rd_next[5:0] = {send_shift_reg, repeating, key_stable_reg,
                tx_ready_s, half_s, online_s};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= rd_next;
        end
    end
endmodule // terminal_keyboard_line_router
